// ### hdl/mag_ctrl_pkg.sv
// package: register map, field layouts and reset values of the magnetometer control bank
// Functional notes
// - power register reachable even in suspend
// - soft reset needs bits 7 and 1
// - soft reset restores defaults except power register
// - soft reset always ends in sleep
// - soft reset ignored while suspended
// - trigger bits self-clear after soft reset
// - suspend then sleep gives full power-on reset
// - bit 2 selects three-wire serial mode
// - power bit: one sleep, zero suspend
// - mode register field layout
// - data rate code to hertz table
// - opmode codes; host avoids reserved code
// - overrun flag enable, overflow to pin
// - threshold axis enables, active low
// - disabled channel keeps last values
// - z disabled forces resistance to zero
// - disabled axes still evaluate thresholds
// - data ready and interrupt pin mapping
// - channel enables, active low
// - pin polarity bits, default active high
// - interrupt latch until status read
// - low and high threshold registers
// - interrupt status bit layout
package mag_ctrl_pkg;

  localparam int ADDR_W   = 7;
  localparam int SNAP_N   = 9;
  localparam int CNT_W    = 5;

  // register addresses
  localparam logic [6:0] ADDR_RH_LSB = 7'h48;
  localparam logic [6:0] ADDR_RH_MSB = 7'h49;
  localparam logic [6:0] ADDR_STAT   = 7'h4A;
  localparam logic [6:0] ADDR_PWR    = 7'h4B;
  localparam logic [6:0] ADDR_MODE   = 7'h4C;
  localparam logic [6:0] ADDR_IRQEN  = 7'h4D;
  localparam logic [6:0] ADDR_PIN    = 7'h4E;
  localparam logic [6:0] ADDR_LOW    = 7'h4F;
  localparam logic [6:0] ADDR_HIGH   = 7'h50;
  localparam logic [6:0] SNAP_BASE   = 7'h48;

  // power register bit positions
  localparam int PWR_SR_HI = 7;
  localparam int PWR_3W    = 2;
  localparam int PWR_SR_LO = 1;
  localparam int PWR_ON    = 0;
  localparam logic [7:0] PWR_MASK = 8'h87;
  localparam logic [7:0] PWR_RST  = 8'h00;

  // serial frame: read flag, then address, then one data byte
  localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
  localparam logic [4:0] BIT_DATA_FIRST = 5'h08;
  localparam logic [4:0] BIT_DATA_LAST = 5'h0F;
  localparam logic [4:0] BIT_END = 5'h10;

  // soft reset duration in system clocks
  localparam int SRST_CYCLES = 4;
  localparam int THR_SHIFT   = 4;

  typedef enum logic [1:0] {
    OP_NORMAL = 2'b00,
    OP_FORCED = 2'b01,
    OP_RSVD   = 2'b10,
    OP_SLEEP  = 2'b11
  } opmode_type;

  typedef enum logic [1:0] {
    ST_SUSPEND = 2'b00,
    ST_AWAKE   = 2'b01,
    ST_SRST    = 2'b10
  } pwr_state_type;

  typedef struct packed {
    logic [1:0] advanced_selftest_field;
    logic [2:0] output_rate;
    opmode_type opmode;
    logic       selftest;
  } mode_reg_type;

  typedef struct packed {
    logic       overrun_en;
    logic       overflow_int_en;
    logic [2:0] high_off;
    logic [2:0] low_off;
  } irq_en_type;

  typedef struct packed {
    logic       data_ready_pin_en;
    logic       int_pin_en;
    logic [2:0] chan_off;
    logic       ready_pin_polarity;
    logic       int_latch;
    logic       int_polarity;
  } pin_cfg_type;

  typedef struct packed {
    logic       overrun;
    logic       overflow;
    logic [2:0] high;
    logic [2:0] low;
  } stat_type;

  localparam mode_reg_type MODE_RST  = '{2'b00, 3'b000, OP_SLEEP, 1'b0};
  localparam irq_en_type   IRQEN_RST = '{1'b0, 1'b0, 3'b111, 3'b111};
  localparam pin_cfg_type  PIN_RST   = '{1'b0, 1'b0, 3'b000, 1'b1, 1'b1, 1'b1};
  localparam logic [7:0]   THR_RST   = 8'h00;

  localparam logic [4:0] RATE_HZ [0:7] = '{5'h0A, 5'h02, 5'h06, 5'h08, 5'h0F, 5'h14, 5'h19, 5'h1E};

  typedef struct packed {
    logic signed [12:0] x;
    logic signed [12:0] y;
    logic signed [14:0] z;
    logic [13:0]        rhall;
    logic               overflow;
  } meas_type;

  typedef struct packed {
    logic                   awake;
    opmode_type             opmode;
    logic [4:0]             rate_hz;
    logic [1:0]             advanced_selftest_field;
    logic                   selftest;
    logic [2:0]             chan_on;
  } cfg_type;

endpackage

// ### hdl/mag_ctrl.sv
// magnetometer control register bank with serial register port
`timescale 1ns/1ps
module mag_ctrl (
  // system clock and reset
  input  wire logic                  CLK_SYS_I,
  input  wire logic                  SRST_I,
  // serial register port, clocked by the host
  input  wire logic                  SCK_I,
  input  wire logic                  CSB_N_I,
  input  wire logic                  SDI_I,
  output logic                       SDI_O,
  output logic                       SDI_OE_O,
  output logic                       SDO_O,
  output logic                       SDO_OE_O,
  // measurement core
  input  wire mag_ctrl_pkg::meas_type MEAS_I,
  input  wire logic                  MEAS_VALID_I,
  input  wire logic                  OVERRUN_I,
  output mag_ctrl_pkg::cfg_type      CFG_O,
  output mag_ctrl_pkg::meas_type     HELD_O,
  // pins
  output logic                       INT_O,
  output logic                       DATA_READY_PIN_O
);
  import mag_ctrl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // link domain: frame shifter, reset by chip select between frames
  logic [CNT_W-1:0]  cnt_r;
  logic [6:0]        sh_r;
  logic [6:0]        lk_addr_r;
  logic              lk_rd_r;
  logic [7:0]        lk_byte;
  logic              wr_tgl_r;
  logic [6:0]        wr_addr_r;
  logic [7:0]        wr_data_r;
  logic              rd_tgl_r;
  logic [6:0]        rd_addr_r;
  logic              sdo_r;
  logic              oe_r;
  logic [7:0]        rd_byte;
  logic [7:0]        snap_r [0:SNAP_N-1];
  logic [7:0]        live [0:SNAP_N-1];

  assign lk_byte = {sh_r, SDI_I};

  always_ff @(posedge SCK_I or posedge CSB_N_I) begin
    if (CSB_N_I) begin
      cnt_r     <= '0;
      sh_r      <= '0;
      lk_addr_r <= '0;
      lk_rd_r   <= 1'b0;
    end else begin
      if (cnt_r != BIT_END) begin
        cnt_r <= cnt_r + 5'h01;
      end
      sh_r <= lk_byte[6:0];
      if (cnt_r == BIT_ADDR_LAST) begin
        lk_addr_r <= lk_byte[6:0];
        lk_rd_r   <= lk_byte[7];
      end
    end
  end

  // events held stable until the next frame; the toggle tells the system side
  always_ff @(posedge SCK_I or posedge SRST_I) begin
    if (SRST_I) begin
      wr_tgl_r  <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
      rd_tgl_r  <= 1'b0;
      rd_addr_r <= '0;
    end else if (!CSB_N_I) begin
      if (cnt_r == BIT_ADDR_LAST && lk_byte[7]) begin
        rd_addr_r <= lk_byte[6:0];
        rd_tgl_r  <= ~rd_tgl_r;
      end
      if (cnt_r == BIT_DATA_LAST && !lk_rd_r) begin
        wr_addr_r <= lk_addr_r;
        wr_data_r <= lk_byte;
        wr_tgl_r  <= ~wr_tgl_r;
      end
    end
  end

  // snapshot is frozen while a frame runs, so it is quasi-static here
  always_comb begin
    rd_byte = 8'h00;
    if (lk_addr_r >= SNAP_BASE && lk_addr_r < SNAP_BASE + 7'(SNAP_N)) begin
      rd_byte = snap_r[4'(lk_addr_r - SNAP_BASE)];
    end
  end

  always_ff @(negedge SCK_I or posedge CSB_N_I) begin
    if (CSB_N_I) begin
      sdo_r <= 1'b0;
      oe_r  <= 1'b0;
    end else begin
      oe_r  <= lk_rd_r && cnt_r >= BIT_DATA_FIRST && cnt_r != BIT_END;
      sdo_r <= rd_byte[3'(~cnt_r[2:0])];
    end
  end

  logic three_wire;
  assign three_wire = snap_r[4'(ADDR_PWR - SNAP_BASE)][PWR_3W];
  assign SDO_O    = sdo_r;
  assign SDI_O    = sdo_r;
  assign SDO_OE_O = oe_r && !three_wire;
  assign SDI_OE_O = oe_r && three_wire;

  //////////////////////////////////////////////////////////////////////////////
  // crossings into the system domain
  logic              csb_s1_r;
  logic              csb_s2_r;
  logic [2:0]        wr_sync_r;
  logic [2:0]        rd_sync_r;
  logic              wr_pls;
  logic              rd_pls;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      csb_s1_r  <= 1'b1;
      csb_s2_r  <= 1'b1;
      wr_sync_r <= '0;
      rd_sync_r <= '0;
    end else begin
      csb_s1_r  <= CSB_N_I;
      csb_s2_r  <= csb_s1_r;
      wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
      rd_sync_r <= {rd_sync_r[1:0], rd_tgl_r};
    end
  end

  assign wr_pls = wr_sync_r[2] ^ wr_sync_r[1];
  assign rd_pls = rd_sync_r[2] ^ rd_sync_r[1];

  //////////////////////////////////////////////////////////////////////////////
  // power state and soft reset
  pwr_state_type     state_r;
  logic [2:0]        srst_cnt_r;
  logic [7:0]        pwr_r;
  logic              pwr_wr;
  logic              srst_go;
  logic              srst_done;
  logic              regs_dflt;
  logic              cfg_wr;

  assign pwr_wr    = wr_pls && wr_addr_r == ADDR_PWR;
  assign srst_go   = pwr_wr && wr_data_r[PWR_SR_HI] && wr_data_r[PWR_SR_LO] && wr_data_r[PWR_ON];
  assign srst_done = state_r == ST_SRST && srst_cnt_r == 3'(SRST_CYCLES - 1);
  assign regs_dflt = state_r != ST_AWAKE;
  assign cfg_wr    = wr_pls && state_r == ST_AWAKE;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      state_r <= ST_SUSPEND;
    end else if (pwr_wr && !wr_data_r[PWR_ON]) begin
      state_r <= ST_SUSPEND;
    end else begin
      unique case (state_r)
        ST_SUSPEND: begin
          if (pwr_wr) begin
            state_r <= ST_AWAKE;
          end
        end
        ST_AWAKE: begin
          if (srst_go) begin
            state_r <= ST_SRST;
          end
        end
        ST_SRST: begin
          if (srst_done) begin
            state_r <= ST_AWAKE;
          end
        end
        default: begin
          state_r <= ST_SUSPEND;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || state_r != ST_SRST) begin
      srst_cnt_r <= '0;
    end else begin
      srst_cnt_r <= srst_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      pwr_r <= PWR_RST;
    end else if (pwr_wr) begin
      pwr_r <= wr_data_r & PWR_MASK;
      if (state_r == ST_SUSPEND || !wr_data_r[PWR_ON]) begin
        pwr_r[PWR_SR_HI] <= 1'b0;
        pwr_r[PWR_SR_LO] <= 1'b0;
      end
    end else if (srst_done) begin
      pwr_r[PWR_SR_HI] <= 1'b0;
      pwr_r[PWR_SR_LO] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers, back at defaults outside the awake state
  mode_reg_type      mode_r;
  irq_en_type        irqen_r;
  pin_cfg_type       pin_r;
  logic [7:0]        low_r;
  logic [7:0]        high_r;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || regs_dflt) begin
      mode_r  <= MODE_RST;
      irqen_r <= IRQEN_RST;
      pin_r   <= PIN_RST;
      low_r   <= THR_RST;
      high_r  <= THR_RST;
    end else if (cfg_wr) begin
      unique case (wr_addr_r)
        ADDR_MODE:  mode_r  <= mode_reg_type'(wr_data_r);
        ADDR_IRQEN: irqen_r <= irq_en_type'(wr_data_r);
        ADDR_PIN:   pin_r   <= pin_cfg_type'(wr_data_r);
        ADDR_LOW:   low_r   <= wr_data_r;
        ADDR_HIGH:  high_r  <= wr_data_r;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      CFG_O <= '0;
    end else begin
      CFG_O.awake                   <= state_r == ST_AWAKE;
      CFG_O.opmode                  <= mode_r.opmode;
      CFG_O.rate_hz                 <= RATE_HZ[mode_r.output_rate];
      CFG_O.advanced_selftest_field <= mode_r.advanced_selftest_field;
      CFG_O.selftest                <= mode_r.selftest;
      CFG_O.chan_on                 <= ~pin_r.chan_off;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // held measurement values and threshold evaluation
  meas_type          held_r;
  logic              data_ready_pin_r;
  stat_type          stat_r;
  stat_type          cond;
  logic signed [14:0] axis_v [0:2];

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      held_r <= '0;
    end else begin
      if (MEAS_VALID_I) begin
        if (!pin_r.chan_off[0]) held_r.x <= MEAS_I.x;
        if (!pin_r.chan_off[1]) held_r.y <= MEAS_I.y;
        if (!pin_r.chan_off[2]) held_r.z <= MEAS_I.z;
        if (!pin_r.chan_off[2]) held_r.rhall <= MEAS_I.rhall;
        held_r.overflow <= MEAS_I.overflow;
      end
      if (pin_r.chan_off[2]) begin
        held_r.rhall <= '0;
      end
    end
  end
  assign HELD_O = held_r;

  assign axis_v[0] = 15'(held_r.x);
  assign axis_v[1] = 15'(held_r.y);
  assign axis_v[2] = held_r.z;

  // thresholds read on held values, so a disabled axis still trips
  always_comb begin
    cond          = '0;
    cond.overrun  = OVERRUN_I && irqen_r.overrun_en;
    cond.overflow = held_r.overflow;
    for (int i = 0; i < 3; i++) begin
      cond.high[i] = !irqen_r.high_off[i] && (axis_v[i] >>> THR_SHIFT) > 15'(signed'(high_r));
      cond.low[i]  = !irqen_r.low_off[i] && (axis_v[i] >>> THR_SHIFT) < 15'(signed'(low_r));
    end
  end

  logic stat_rd;
  assign stat_rd = rd_pls && rd_addr_r == ADDR_STAT;

  // set wins over the clearing read
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || regs_dflt) begin
      stat_r <= '0;
    end else if (!pin_r.int_latch) begin
      stat_r <= cond;
    end else begin
      stat_r <= (stat_rd ? stat_type'(8'h00) : stat_r) | cond;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I || regs_dflt) begin
      data_ready_pin_r <= 1'b0;
    end else begin
      data_ready_pin_r <= MEAS_VALID_I || (data_ready_pin_r && !(rd_pls && rd_addr_r == ADDR_RH_LSB));
    end
  end

  logic int_act;
  assign int_act = pin_r.int_pin_en && (|stat_r.high || |stat_r.low ||
                   (stat_r.overflow && irqen_r.overflow_int_en));

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      INT_O  <= 1'b0;
      DATA_READY_PIN_O <= 1'b0;
    end else begin
      INT_O  <= pin_r.int_polarity ? int_act : !int_act;
      DATA_READY_PIN_O <= pin_r.ready_pin_polarity ? (pin_r.data_ready_pin_en && data_ready_pin_r) :
                !(pin_r.data_ready_pin_en && data_ready_pin_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read image, refreshed only between frames
  always_comb begin
    for (int i = 0; i < SNAP_N; i++) begin
      live[i] = 8'h00;
    end
    live[0] = {held_r.rhall[5:0], 1'b0, data_ready_pin_r};
    live[1] = held_r.rhall[13:6];
    live[2] = stat_r;
    live[3] = pwr_r;
    live[4] = mode_r;
    live[5] = irqen_r;
    live[6] = pin_r;
    live[7] = low_r;
    live[8] = high_r;
    if (state_r == ST_SUSPEND) begin
      for (int i = 0; i < SNAP_N; i++) begin
        if (i != int'(ADDR_PWR - SNAP_BASE)) live[i] = 8'h00;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      for (int i = 0; i < SNAP_N; i++) snap_r[i] <= 8'h00;
    end else if (csb_s2_r) begin
      for (int i = 0; i < SNAP_N; i++) snap_r[i] <= live[i];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  srst_trig_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    $rose(state_r == ST_SRST) |-> $past(srst_go))
    else $error("soft reset entered without both trigger bits");
  srst_len_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    $rose(state_r == ST_SRST) |=> (state_r == ST_SRST && irqen_r == IRQEN_RST)[*3] ##1 state_r != ST_SRST)
    else $error("soft reset length or defaults wrong");
  srst_sleep_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    $past(state_r == ST_SRST) && state_r == ST_AWAKE |-> mode_r.opmode == OP_SLEEP)
    else $error("soft reset did not end in sleep");
  susp_ignore_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    state_r == ST_SUSPEND && !pwr_wr |=> state_r == ST_SUSPEND)
    else $error("left suspend without power write");
  trig_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    srst_done |=> !pwr_r[PWR_SR_HI] && !pwr_r[PWR_SR_LO])
    else $error("trigger bits not cleared");
  wake_por_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    $past(state_r == ST_SUSPEND) && state_r == ST_AWAKE |-> pin_r == PIN_RST && low_r == THR_RST)
    else $error("wake did not restore defaults");
  power_up_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    pwr_wr && wr_data_r[PWR_ON] && state_r == ST_SUSPEND |=> state_r == ST_AWAKE ##1 CFG_O.awake)
    else $error("power bit did not wake");
  hold_x_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    pin_r.chan_off[0] |=> $stable(held_r.x))
    else $error("disabled x channel changed");
  rhall_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    pin_r.chan_off[2] |=> held_r.rhall == 14'h0000)
    else $error("resistance not zero with z off");
  latch_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    pin_r.int_latch && stat_r.low[0] && !stat_rd && !regs_dflt |=> stat_r.low[0])
    else $error("latched flag dropped without read");
  low_off_a: assert property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    irqen_r.low_off[1] && !stat_r.low[1] && !regs_dflt |=> !stat_r.low[1])
    else $error("disabled low threshold set flag");

  srst_seen_c: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I) srst_done);
  wake_seen_c: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I)
    state_r == ST_SUSPEND ##1 state_r == ST_AWAKE);
  int_seen_c: cover property (@(posedge CLK_SYS_I) disable iff (SRST_I) int_act && stat_rd);

endmodule

// ### tb/mag_host_model.sv
// host side model: drives serial register frames on the link
`timescale 1ns/1ps
module mag_host_model (
  // serial pins
  output logic       SCK_O,
  output logic       CSB_N_O,
  output logic       SDI_DRV_O,
  output logic       SDI_EN_O,
  input  wire logic  SDO_I,
  input  wire logic  SDI_I,
  // read result
  output logic [7:0] RD_DATA_O,
  output logic       RD_DONE_O
);
  initial begin
    SCK_O     = 1'b0;
    CSB_N_O   = 1'b0;
    SDI_DRV_O = 1'b0;
    SDI_EN_O  = 1'b0;
    RD_DATA_O = 8'h00;
    RD_DONE_O = 1'b0;
    // deselect just after time zero so the frame logic's clear sees a rising edge
    #1;
    CSB_N_O   = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one frame: read flag, seven address bits, one data byte, msb first
  task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] wd, input logic tw);
    logic [15:0] sh;
    logic [7:0]  rx;
    sh      = {rd, a, wd};
    rx      = 8'h00;
    CSB_N_O = 1'b0;
    // select leads the first clock edge by more than three system clocks
    #175;
    for (int i = 15; i >= 0; i--) begin
      // let go of the line in the read data phase so the device can turn it round
      SDI_EN_O  = !(rd && i < 8);
      SDI_DRV_O = sh[i];
      #7.5;
      SCK_O = 1'b1;
      if (i < 8) rx = {rx[6:0], tw ? SDI_I : SDO_I};
      #7.5;
      SCK_O = 1'b0;
    end
    #7.5;
    CSB_N_O  = 1'b1;
    SDI_EN_O = 1'b0;
    if (rd) begin
      RD_DATA_O = rx;
      RD_DONE_O = 1'b1;
      #1;
      RD_DONE_O = 1'b0;
    end
    // gap between frames longer than four system clocks
    #210;
  endtask
endmodule

// ### tb/magnetometer_mode_irq_ctrl_tb_top.sv
// self-checking bench for the magnetometer control bank
`timescale 1ns/1ps
module magnetometer_mode_irq_ctrl_tb_top;
  import mag_ctrl_pkg::*;
  logic       clk;
  logic       srst;
  logic       sck, csb_n, sdi_drv, sdi_en, sdi_wire, sdo_wire;
  logic       dev_sdi, dev_sdi_oe, dev_sdo, dev_sdo_oe;
  logic       mvalid, ovr, irq_pin, rdy_pin, rd_done, tw;
  meas_type   meas, held, m1, m2;
  cfg_type    cfg;
  logic [7:0] rd_data, v;
  logic [7:0] exp_q [$];
  int         mismatches, cmp_count;
  logic [4:0] hz [0:7]   = '{5'h0A, 5'h02, 5'h06, 5'h08, 5'h0F, 5'h14, 5'h19, 5'h1E};
  logic [1:0] opm [0:2]  = '{2'b00, 2'b01, 2'b11};
  logic [7:0] dflt [0:4] = '{8'h06, 8'h3F, 8'h07, 8'h00, 8'h00};

  always #25 clk = ~clk;
  // a released line shows the inverse of the device's current output register bit, never a lucky copy
  assign sdo_wire = dev_sdo_oe ? dev_sdo : ~dev_sdo;
  assign sdi_wire = dev_sdi_oe ? dev_sdi : (sdi_en ? sdi_drv : ~dev_sdi);

  mag_ctrl i_mag_ctrl (
    .CLK_SYS_I    (clk),
    .SRST_I       (srst),
    .SCK_I        (sck),
    .CSB_N_I      (csb_n),
    .SDI_I        (sdi_wire),
    .SDI_O        (dev_sdi),
    .SDI_OE_O     (dev_sdi_oe),
    .SDO_O        (dev_sdo),
    .SDO_OE_O     (dev_sdo_oe),
    .MEAS_I       (meas),
    .MEAS_VALID_I (mvalid),
    .OVERRUN_I    (ovr),
    .CFG_O        (cfg),
    .HELD_O       (held),
    .INT_O        (irq_pin),
    .DATA_READY_PIN_O       (rdy_pin)
  );
  mag_host_model i_mag_host_model (
    .SCK_O     (sck),
    .CSB_N_O   (csb_n),
    .SDI_DRV_O (sdi_drv),
    .SDI_EN_O  (sdi_en),
    .SDO_I     (sdo_wire),
    .SDI_I     (sdi_wire),
    .RD_DATA_O (rd_data),
    .RD_DONE_O (rd_done)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (e !== g) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_mag_host_model.frame(1'b0, a, d, tw);
    // write lands a few clocks later; a soft reset adds its own four
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_mag_host_model.frame(1'b1, a, 8'h00, tw);
  endtask
  task automatic send(input meas_type m);
    @(negedge clk);
    meas   = m;
    mvalid = 1'b1;
    @(negedge clk);
    mvalid = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic meas_type rnd();
    logic [63:0] r;
    meas_type    m;
    r          = {$urandom, $urandom};
    m          = r[55:0];
    m.overflow = 1'b0;
    return m;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge rd_done) begin
    if (exp_q.size() > 0) chk("read data", 64'(exp_q.pop_front()), 64'(rd_data));
    else chk("read count", 64'h0, 64'h1);
  end
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    clk        = 1'b0;
    srst       = 1'b0;
    meas       = '0;
    mvalid     = 1'b0;
    ovr        = 1'b0;
    tw         = 1'b0;
    mismatches = 0;
    cmp_count  = 0;
    void'($urandom(10));
    // raise reset after time zero so the asynchronous clears see an edge
    #1;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("int pin", 64'h0, 64'(irq_pin));
    chk("ready pin", 64'h0, 64'(rdy_pin));
    rd(ADDR_PWR, 8'h00);
    rd(ADDR_MODE, 8'h00);
    wr(ADDR_LOW, 8'h5A);
    wr(ADDR_PWR, 8'h01);
    chk("awake", 64'h1, 64'(cfg.awake));
    for (int i = 0; i < 5; i++) rd(ADDR_MODE + 7'(i), dflt[i]);
    for (int r = 0; r < 8; r++) begin
      v = {2'($urandom), 3'(r), opm[r % 3], 1'($urandom)};
      wr(ADDR_MODE, v);
      chk("rate", 64'(hz[r]), 64'(cfg.rate_hz));
      chk("opmode", 64'(v[2:1]), 64'(cfg.opmode));
      chk("selftest", 64'({v[7:6], v[0]}), 64'({cfg.advanced_selftest_field, cfg.selftest}));
      rd(ADDR_MODE, v);
    end
    for (int i = 1; i < 5; i++) begin
      v = 8'($urandom);
      wr(ADDR_MODE + 7'(i), v);
      rd(ADDR_MODE + 7'(i), v);
    end
    // one trigger bit alone must not reset
    wr(ADDR_LOW, 8'h33);
    wr(ADDR_PWR, 8'h81);
    rd(ADDR_LOW, 8'h33);
    wr(ADDR_PWR, 8'h83);
    chk("opmode", 64'(OP_SLEEP), 64'(cfg.opmode));
    rd(ADDR_PWR, 8'h01);
    rd(ADDR_LOW, 8'h00);
    rd(ADDR_MODE, 8'h06);
    wr(ADDR_PWR, 8'h05);
    tw = 1'b1;
    rd(ADDR_PWR, 8'h05);
    rd(ADDR_MODE, 8'h06);
    wr(ADDR_PWR, 8'h01);
    tw = 1'b0;
    rd(ADDR_PWR, 8'h01);
    wr(ADDR_LOW, 8'h33);
    wr(ADDR_PWR, 8'h00);
    chk("awake", 64'h0, 64'(cfg.awake));
    wr(ADDR_PWR, 8'h82);
    rd(ADDR_PWR, 8'h00);
    wr(ADDR_PWR, 8'h01);
    rd(ADDR_LOW, 8'h00);
    m1 = rnd();
    send(m1);
    chk("held", 64'(m1), 64'(held));
    wr(ADDR_PIN, 8'h27);
    chk("channels", 64'(3'b011), 64'(cfg.chan_on));
    m2 = rnd();
    send(m2);
    chk("held", 64'({m2.x, m2.y, m1.z, 14'h0000, m2.overflow}), 64'(held));
    // x goes high, then its channel is shut so the next sample cannot lower it
    m1   = '0;
    m1.x = 13'h0200;
    send(m1);
    wr(ADDR_HIGH, 8'h10);
    wr(ADDR_PIN, 8'h4F);
    wr(ADDR_IRQEN, 8'h37);
    m2 = '0;
    send(m2);
    chk("int pin", 64'h1, 64'(irq_pin));
    rd(ADDR_STAT, 8'h08);
    wr(ADDR_PIN, 8'h45);
    send(m2);
    chk("int pin", 64'h0, 64'(irq_pin));
    wr(ADDR_PIN, 8'h44);
    chk("int pin", 64'h1, 64'(irq_pin));
    wr(ADDR_PIN, 8'h85);
    m1 = rnd();
    send(m1);
    chk("ready pin", 64'h1, 64'(rdy_pin));
    rd(ADDR_RH_LSB, {m1.rhall[5:0], 2'b01});
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("ready pin", 64'h0, 64'(rdy_pin));
    ovr = 1'b1;
    wr(ADDR_IRQEN, 8'hBF);
    rd(ADDR_STAT, 8'h80);
    @(negedge clk);
    ovr = 1'b0;
    // a latched low flag outlives its condition until status is read
    wr(ADDR_PIN, 8'h47);
    wr(ADDR_LOW, 8'h10);
    wr(ADDR_IRQEN, 8'h3E);
    send(m2);
    m1   = '0;
    m1.x = 13'h0200;
    send(m1);
    chk("int pin", 64'h1, 64'(irq_pin));
    rd(ADDR_STAT, 8'h01);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("int pin", 64'h0, 64'(irq_pin));
    // overflow reaches the pin only through its route bit
    wr(ADDR_IRQEN, 8'h7F);
    m1.overflow = 1'b1;
    send(m1);
    chk("int pin", 64'h1, 64'(irq_pin));
    wr(ADDR_IRQEN, 8'h3F);
    chk("int pin", 64'h0, 64'(irq_pin));
    rd(ADDR_STAT, 8'h40);
    repeat (20) @(posedge clk);
    give_verdict();
  end
endmodule
